// file: rtl/srm_regs.svh
/*
  Constants for the special register move unit: bit positions, masks, reset values and sizes.
  Assumes big-endian bit numbering folded onto [31:0] words, doc bit 32+k at position 31-k.
*/
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

`define SRM_WORD_W 32
`define SRM_OPND_W 64
`define SRM_FIELDS 8
`define SRM_NIBBLE 4
`define SRM_WORD_HI 31
`define SRM_ZERO32 32'h0000_0000
`define SRM_ONES32 32'hffff_ffff
`define SRM_ONE32 32'h0000_0001

// operand slices for messages, low word of a 64-bit operand
`define SRM_MSG_TYPE_HI 31
`define SRM_MSG_TYPE_LO 27
`define SRM_MSG_PAY_HI 26
`define SRM_MSG_TYPE_W 5
`define SRM_MSG_PAY_W 27
`define SRM_MSG_TYPES 32

// status/control register bit positions
`define SRM_FP_FX 31
`define SRM_FP_FEX 30
`define SRM_FP_VX 29
`define SRM_FP_OX 28
`define SRM_FP_UX 27
`define SRM_FP_ZX 26
`define SRM_FP_XX 25
`define SRM_FP_VE 7
`define SRM_FP_OE 6
`define SRM_FP_UE 5
`define SRM_FP_ZE 4
`define SRM_FP_XE 3
`define SRM_FP_EXC_MASK 32'h1ff8_0700
`define SRM_FP_VX_MASK 32'h01f8_0700
`define SRM_FP_IDX_FEX 5'h01
`define SRM_FP_IDX_VX 5'h02
`define SRM_FP_RESET 32'h0000_0000
`define SRM_CR_FIELD1_HI 27
`define SRM_CR_FIELD1_LO 24
`define SRM_CR_RESET 32'h0000_0000

// machine state register bit positions
`define SRM_MSR_CM 31
`define SRM_MSR_GS 28
`define SRM_MSR_WE 18
`define SRM_MSR_CE 17
`define SRM_MSR_EE 16
`define SRM_MSR_PR 14
`define SRM_MSR_FP 13
`define SRM_MSR_ME 12
`define SRM_MSR_GUEST_KEEP 32'h1004_1000
`define SRM_MSR_RESET 32'h0000_0000

// device control registers
`define SRM_DCRN_W 10
`define SRM_DCR_AW 5
`define SRM_DCR_DEPTH 32
`define SRM_DCR_HI_ZERO 5'h00

`endif

// file: rtl/srm_pkg.sv
/*
  Types of the special register move unit.
  Assumes the decoder hands one operation kind per request.
*/
package srm_pkg;
  typedef enum logic [3:0] {
    SRM_OP_CR_WRITE,
    SRM_OP_DCR_WRITE,
    SRM_OP_MSR_WRITE,
    SRM_OP_FP_BIT_CLR,
    SRM_OP_FP_BIT_SET,
    SRM_OP_FP_FIELDS,
    SRM_OP_FP_FIELD_IMM,
    SRM_OP_MSG_SEND,
    SRM_OP_MSG_CLR
  } srm_op_type;
endpackage : srm_pkg

// file: rtl/srm_dcr_mem.sv
/*
  Device control register storage: one write port, one registered read port.
  Assumes both ports run on the core clock; the array itself has no reset.
*/
`include "srm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module srm_dcr_mem (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [`SRM_DCR_AW-1:0] wr_addr,
  input wire logic [`SRM_WORD_W-1:0] wr_data,
  input wire logic [`SRM_DCR_AW-1:0] rd_addr,
  output logic [`SRM_WORD_W-1:0] rd_data
);
  logic [`SRM_WORD_W-1:0] mem [`SRM_DCR_DEPTH];
  logic [`SRM_WORD_W-1:0] rd_data_r;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read returns the old word on a same-address write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= `SRM_ZERO32;
    end else begin
      rd_data_r <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;
endmodule : srm_dcr_mem
`default_nettype wire

// file: rtl/srm_fp_merge.sv
/*
  Merges a write into the floating-point status/control word and recomputes the summary bits.
  Assumes the enabled and invalid summary positions are always recomputed, whatever sel covers.
*/
`include "srm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module srm_fp_merge (
  input wire logic [`SRM_WORD_W-1:0] old_val,
  input wire logic [`SRM_WORD_W-1:0] cand,
  input wire logic [`SRM_WORD_W-1:0] sel,
  input wire logic fx_auto,
  output logic [`SRM_WORD_W-1:0] result
);
  logic [`SRM_WORD_W-1:0] v;
  logic rise;
  logic enabled_exception_summary;

  always_comb begin
    v = (old_val & ~sel) | (cand & sel);
    rise = |(v & ~old_val & `SRM_FP_EXC_MASK);
    enabled_exception_summary = (v[`SRM_FP_OX] & v[`SRM_FP_OE]) | (v[`SRM_FP_UX] & v[`SRM_FP_UE]) |
          (v[`SRM_FP_ZX] & v[`SRM_FP_ZE]) | (v[`SRM_FP_XX] & v[`SRM_FP_XE]) |
          ((|(v & `SRM_FP_VX_MASK)) & v[`SRM_FP_VE]);
    result = v;
    // a directly written summary bit keeps the written value
    result[`SRM_FP_FX] = v[`SRM_FP_FX] | (fx_auto & rise);
    result[`SRM_FP_VX] = |(v & `SRM_FP_VX_MASK);
    result[`SRM_FP_FEX] = enabled_exception_summary;
  end
endmodule : srm_fp_merge
`default_nettype wire

// file: rtl/srm_top.sv
/*
  Special register move unit: condition, fp status, machine state and device control writes,
  plus message send and message clear.
  Assumes a decoder presents one operation with op_valid and holds it until op_ready is seen;
  incoming message and interrupt-taken strobes are on the core clock.
*/
// Overview of operation
// - message clear takes type from operand bits 32-36, cancels that pending exception.
// - a cancelled pending message stays cancelled when its enable later turns on.
// - message send broadcasts type bits 32-36 and payload bits 37-63.
// - every sent message is delivered; none is dropped; receivers may ignore it.
// - a message send orders like a store against a full memory barrier.
// - message send, message clear and device register writes need hypervisor state.
// - condition write copies each masked 4-bit source field; unmasked fields stay.
// - device register write stores source bits 32-63 into the selected register.
// - bit clear zeroes status bit index+32, except bits 33 and 34.
// - bit set sets status bit index+32, updates exception summary; not 33 or 34.
// - with record bit, summary, enabled, invalid and overflow go to condition field 1.
// - masked field move loads status field i+8 from the source low word.
// - masked field move changes exception summary only when mask bit 0 is set.
// - top field write takes bits 32 and 35 directly; 33 and 34 are computed.
// - immediate field move writes its nibble; summary changes only for field 0.
// - fp status moves with fp unavailable raise an unavailable exception instead.
// - machine state write loads bits 32-63; width bit change clears fetch high half.
// - in guest supervisor state, guest, machine check and protected bits are kept.
// - machine state write allowed in guest supervisor or higher; user gets privilege fault.
// - interrupt enable changes act at completion so pending interrupts are taken next.
`include "srm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module srm_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire srm_pkg::srm_op_type op_kind,
  input wire logic [`SRM_OPND_W-1:0] op_operand,
  input wire logic [`SRM_FIELDS-1:0] op_field_mask,
  input wire logic [4:0] op_index,
  input wire logic [`SRM_NIBBLE-1:0] op_imm,
  input wire logic op_record,
  input wire logic [`SRM_DCRN_W-1:0] op_dcrn,
  input wire logic [`SRM_WORD_W-1:0] guest_protect_register,
  input wire logic msg_rx_valid,
  input wire logic [`SRM_MSG_TYPE_W-1:0] msg_rx_type,
  input wire logic msg_irq_taken,
  input wire logic [`SRM_MSG_TYPE_W-1:0] msg_irq_taken_type,
  input wire logic msg_tx_ready,
  input wire logic barrier_req,
  input wire logic [`SRM_DCR_AW-1:0] dcr_rd_addr,
  output logic op_ready,
  output logic op_done,
  output logic exc_priv,
  output logic exc_fp_unavail,
  output logic [`SRM_WORD_W-1:0] condition_register,
  output logic [`SRM_WORD_W-1:0] fp_status_control_reg,
  output logic [`SRM_WORD_W-1:0] machine_state_reg,
  output logic fetch_hi_clear,
  output logic irq_recheck,
  output logic msg_tx_valid,
  output logic [`SRM_MSG_TYPE_W-1:0] msg_tx_type,
  output logic [`SRM_MSG_PAY_W-1:0] msg_tx_payload,
  output logic [`SRM_MSG_TYPES-1:0] msg_pending,
  output logic barrier_ack,
  output logic [`SRM_WORD_W-1:0] dcr_rd_data
);
  // expands an 8-bit field mask into nibble selects, field 0 at the top
  function automatic logic [`SRM_WORD_W-1:0] nibble_mask(input logic [`SRM_FIELDS-1:0] m);
    logic [`SRM_WORD_W-1:0] r;
    r = `SRM_ZERO32;
    for (int i = 0; i < `SRM_FIELDS; i++) begin
      if (m[i]) begin
        r[`SRM_WORD_HI - `SRM_NIBBLE*i -: `SRM_NIBBLE] = {`SRM_NIBBLE{1'b1}};
      end
    end
    return r;
  endfunction : nibble_mask

  // one-hot of a message type
  function automatic logic [`SRM_MSG_TYPES-1:0] type_hot(input logic [`SRM_MSG_TYPE_W-1:0] t);
    return `SRM_ONE32 << t;
  endfunction : type_hot

  logic op_ready_r;
  logic op_done_r;
  logic exc_priv_r;
  logic exc_fp_unavail_r;
  logic [`SRM_WORD_W-1:0] cr_r;
  logic [`SRM_WORD_W-1:0] fp_r;
  logic [`SRM_WORD_W-1:0] msr_r;
  logic fetch_hi_clear_r;
  logic irq_recheck_r;
  logic msg_tx_valid_r;
  logic [`SRM_MSG_TYPE_W-1:0] msg_tx_type_r;
  logic [`SRM_MSG_PAY_W-1:0] msg_tx_payload_r;
  logic [`SRM_MSG_TYPES-1:0] pending_r;
  logic barrier_ack_r;

  logic take;
  logic is_fp;
  logic is_hv_op;
  logic hyper;
  logic guest_sup;
  logic user;
  logic fault_fp;
  logic fault_priv;
  logic exec;
  logic [`SRM_WORD_W-1:0] src_lo;
  logic [`SRM_WORD_W-1:0] fp_sel;
  logic [`SRM_WORD_W-1:0] fp_cand;
  logic fp_fx_auto;
  logic [`SRM_WORD_W-1:0] fp_merged;
  logic [`SRM_WORD_W-1:0] msr_keep;
  logic [`SRM_WORD_W-1:0] msr_nxt;
  logic [`SRM_DCRN_W-1:0] dcr_num;
  logic dcr_wr;
  logic tx_done;

  assign src_lo = op_operand[`SRM_WORD_W-1:0];
  assign take = op_valid & op_ready_r;
  assign tx_done = msg_tx_valid_r & msg_tx_ready;

  // privilege state follows the stored machine state word
  always_comb begin
    user = msr_r[`SRM_MSR_PR];
    guest_sup = ~msr_r[`SRM_MSR_PR] & msr_r[`SRM_MSR_GS];
    hyper = ~msr_r[`SRM_MSR_PR] & ~msr_r[`SRM_MSR_GS];
    is_fp = 1'b0;
    is_hv_op = 1'b0;
    case (op_kind)
      srm_pkg::SRM_OP_FP_BIT_CLR,
      srm_pkg::SRM_OP_FP_BIT_SET,
      srm_pkg::SRM_OP_FP_FIELDS,
      srm_pkg::SRM_OP_FP_FIELD_IMM: begin
        is_fp = 1'b1;
      end
      srm_pkg::SRM_OP_DCR_WRITE,
      srm_pkg::SRM_OP_MSG_SEND,
      srm_pkg::SRM_OP_MSG_CLR: begin
        is_hv_op = 1'b1;
      end
      default: begin
        is_fp = 1'b0;
      end
    endcase
    fault_fp = is_fp & ~msr_r[`SRM_MSR_FP];
    fault_priv = (is_hv_op & ~hyper) |
                 ((op_kind == srm_pkg::SRM_OP_MSR_WRITE) & user);
    exec = take & ~fault_fp & ~fault_priv;
  end

  // status word write selects; summary positions 33 and 34 never take operand bits
  always_comb begin
    fp_sel = `SRM_ZERO32;
    fp_cand = `SRM_ZERO32;
    fp_fx_auto = 1'b0;
    case (op_kind)
      srm_pkg::SRM_OP_FP_BIT_CLR: begin
        if (op_index != `SRM_FP_IDX_FEX && op_index != `SRM_FP_IDX_VX) begin
          fp_sel = `SRM_ONE32 << (`SRM_WORD_HI - op_index);
        end
      end
      srm_pkg::SRM_OP_FP_BIT_SET: begin
        if (op_index != `SRM_FP_IDX_FEX && op_index != `SRM_FP_IDX_VX) begin
          fp_sel = `SRM_ONE32 << (`SRM_WORD_HI - op_index);
        end
        fp_cand = `SRM_ONES32;
        fp_fx_auto = 1'b1;
      end
      srm_pkg::SRM_OP_FP_FIELDS: begin
        // the top nibble mask covers the summary bit only when mask bit 0 is set
        fp_sel = nibble_mask(op_field_mask);
        fp_cand = src_lo;
      end
      srm_pkg::SRM_OP_FP_FIELD_IMM: begin
        fp_sel = nibble_mask(`SRM_FIELDS'(1) << op_index[2:0]);
        fp_cand = {`SRM_FIELDS{op_imm}};
      end
      default: begin
        fp_sel = `SRM_ZERO32;
      end
    endcase
  end

  srm_fp_merge u_fp_merge (
    .old_val(fp_r),
    .cand(fp_cand),
    .sel(fp_sel),
    .fx_auto(fp_fx_auto),
    .result(fp_merged)
  );

  // guest writes keep guest state, machine check enable, wait enable and protected bits
  always_comb begin
    msr_keep = guest_sup ? (`SRM_MSR_GUEST_KEEP | guest_protect_register) : `SRM_ZERO32;
    msr_nxt = (msr_r & msr_keep) | (src_lo & ~msr_keep);
  end

  // the number field arrives with its halves exchanged
  assign dcr_num = {op_dcrn[`SRM_DCR_AW-1:0], op_dcrn[`SRM_DCRN_W-1:`SRM_DCR_AW]};
  // numbers beyond the implemented registers are silently dropped
  assign dcr_wr = exec & (op_kind == srm_pkg::SRM_OP_DCR_WRITE) &
                  (dcr_num[`SRM_DCRN_W-1:`SRM_DCR_AW] == `SRM_DCR_HI_ZERO);

  srm_dcr_mem u_dcr_mem (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(dcr_wr),
    .wr_addr(dcr_num[`SRM_DCR_AW-1:0]),
    .wr_data(src_lo),
    .rd_addr(dcr_rd_addr),
    .rd_data(dcr_rd_data)
  );

  // request handshake and completion pulses; a send holds off new requests until delivered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_ready_r <= 1'b1;
      op_done_r <= 1'b0;
      exc_priv_r <= 1'b0;
      exc_fp_unavail_r <= 1'b0;
    end else begin
      exc_priv_r <= take & fault_priv;
      exc_fp_unavail_r <= take & fault_fp;
      if (exec && op_kind == srm_pkg::SRM_OP_MSG_SEND) begin
        op_ready_r <= 1'b0;
        op_done_r <= 1'b0;
      end else if (tx_done) begin
        op_ready_r <= 1'b1;
        op_done_r <= 1'b1;
      end else begin
        op_done_r <= exec;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cr_r <= `SRM_CR_RESET;
    end else if (exec && op_kind == srm_pkg::SRM_OP_CR_WRITE) begin
      cr_r <= (cr_r & ~nibble_mask(op_field_mask)) | (src_lo & nibble_mask(op_field_mask));
    end else if (exec && is_fp && op_record) begin
      cr_r[`SRM_CR_FIELD1_HI:`SRM_CR_FIELD1_LO] <= fp_merged[`SRM_FP_FX:`SRM_FP_OX];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fp_r <= `SRM_FP_RESET;
    end else if (exec && is_fp) begin
      fp_r <= fp_merged;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msr_r <= `SRM_MSR_RESET;
      fetch_hi_clear_r <= 1'b0;
      irq_recheck_r <= 1'b0;
    end else begin
      fetch_hi_clear_r <= 1'b0;
      irq_recheck_r <= 1'b0;
      if (exec && op_kind == srm_pkg::SRM_OP_MSR_WRITE) begin
        msr_r <= msr_nxt;
        fetch_hi_clear_r <= msr_nxt[`SRM_MSR_CM] != msr_r[`SRM_MSR_CM];
        // new enables are visible the cycle the write completes
        irq_recheck_r <= 1'b1;
      end
    end
  end

  // outgoing message holds until the fabric accepts it, so none is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_tx_valid_r <= 1'b0;
      msg_tx_type_r <= `SRM_MSG_TYPE_W'(0);
      msg_tx_payload_r <= `SRM_MSG_PAY_W'(0);
    end else if (exec && op_kind == srm_pkg::SRM_OP_MSG_SEND) begin
      msg_tx_valid_r <= 1'b1;
      msg_tx_type_r <= op_operand[`SRM_MSG_TYPE_HI:`SRM_MSG_TYPE_LO];
      msg_tx_payload_r <= op_operand[`SRM_MSG_PAY_HI:0];
    end else if (tx_done) begin
      msg_tx_valid_r <= 1'b0;
    end
  end

  // pending message exceptions; an arrival in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_r <= `SRM_ZERO32;
    end else begin
      pending_r <= (pending_r &
                    ~((exec && op_kind == srm_pkg::SRM_OP_MSG_CLR) ?
                      type_hot(op_operand[`SRM_MSG_TYPE_HI:`SRM_MSG_TYPE_LO]) : `SRM_ZERO32) &
                    ~(msg_irq_taken ? type_hot(msg_irq_taken_type) : `SRM_ZERO32)) |
                   (msg_rx_valid ? type_hot(msg_rx_type) : `SRM_ZERO32);
    end
  end

  // a barrier completes only once no send is waiting or being started
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      barrier_ack_r <= 1'b0;
    end else begin
      barrier_ack_r <= barrier_req & ~barrier_ack_r & ~msg_tx_valid_r &
                       ~(exec && op_kind == srm_pkg::SRM_OP_MSG_SEND);
    end
  end

  assign op_ready = op_ready_r;
  assign op_done = op_done_r;
  assign exc_priv = exc_priv_r;
  assign exc_fp_unavail = exc_fp_unavail_r;
  assign condition_register = cr_r;
  assign fp_status_control_reg = fp_r;
  assign machine_state_reg = msr_r;
  assign fetch_hi_clear = fetch_hi_clear_r;
  assign irq_recheck = irq_recheck_r;
  assign msg_tx_valid = msg_tx_valid_r;
  assign msg_tx_type = msg_tx_type_r;
  assign msg_tx_payload = msg_tx_payload_r;
  assign msg_pending = pending_r;
  assign barrier_ack = barrier_ack_r;
endmodule : srm_top
`default_nettype wire

// file: verif/srm_checker.sv
/* Checker for srm_top: timing and value relations on the op, message and barrier ports.
   Assumes the design's own ports only; attached by the bind below the module. */
`include "srm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module srm_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire srm_pkg::srm_op_type op_kind,
  input wire logic [63:0] op_operand,
  input wire logic [7:0] op_field_mask,
  input wire logic [4:0] op_index,
  input wire logic [31:0] guest_protect_register,
  input wire logic msg_rx_valid,
  input wire logic msg_tx_ready,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic exc_priv,
  input wire logic exc_fp_unavail,
  input wire logic [31:0] condition_register,
  input wire logic [31:0] fp_status_control_reg,
  input wire logic [31:0] machine_state_reg,
  input wire logic fetch_hi_clear,
  input wire logic irq_recheck,
  input wire logic msg_tx_valid,
  input wire logic [4:0] msg_tx_type,
  input wire logic [26:0] msg_tx_payload,
  input wire logic [31:0] msg_pending,
  input wire logic barrier_ack
);
  logic take;
  logic hv;
  logic fpk;
  logic [31:0] fm;
  assign take = op_valid && op_ready;
  assign hv = !machine_state_reg[14] && !machine_state_reg[28];
  assign fpk = op_kind inside {srm_pkg::SRM_OP_FP_BIT_CLR, srm_pkg::SRM_OP_FP_BIT_SET,
    srm_pkg::SRM_OP_FP_FIELDS, srm_pkg::SRM_OP_FP_FIELD_IMM};
  always_comb begin
    for (int i = 0; i < 8; i++) fm[31-4*i -: 4] = {4{op_field_mask[i]}};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_cr_mask: assert property (
    take && op_kind == srm_pkg::SRM_OP_CR_WRITE |=> condition_register ==
    (($past(condition_register) & ~$past(fm)) | ($past(op_operand[31:0]) & $past(fm))))
    else $error("condition register merge wrong");
  chk_send_fields: assert property (
    take && op_kind == srm_pkg::SRM_OP_MSG_SEND && hv |=> msg_tx_valid &&
    msg_tx_type == $past(op_operand[31:27]) && msg_tx_payload == $past(op_operand[26:0]))
    else $error("message type or payload wrong");
  chk_tx_hold: assert property (
    msg_tx_valid && !msg_tx_ready |=> msg_tx_valid && $stable(msg_tx_type) && $stable(msg_tx_payload))
    else $error("message dropped or changed before delivery");
  chk_send_done: assert property (
    msg_tx_valid && msg_tx_ready |=> op_done && !msg_tx_valid && op_ready)
    else $error("send not completed after delivery");
  chk_barrier_order: assert property (
    msg_tx_valid |-> !barrier_ack)
    else $error("barrier acknowledged with a send outstanding");
  chk_hyp_only: assert property (
    take && !hv && op_kind inside {srm_pkg::SRM_OP_DCR_WRITE, srm_pkg::SRM_OP_MSG_SEND,
    srm_pkg::SRM_OP_MSG_CLR} |=> exc_priv && !op_done && !msg_tx_valid)
    else $error("hypervisor operation ran outside hypervisor state");
  chk_fp_unavail: assert property (
    take && fpk && !machine_state_reg[13] |=> exc_fp_unavail &&
    $stable(fp_status_control_reg) && $stable(condition_register))
    else $error("fp move ran with fp unavailable");
  chk_user_refused: assert property (
    take && op_kind == srm_pkg::SRM_OP_MSR_WRITE && machine_state_reg[14] |=>
    exc_priv && $stable(machine_state_reg))
    else $error("machine state write accepted in user state");
  chk_guest_keep: assert property (
    take && op_kind == srm_pkg::SRM_OP_MSR_WRITE && !machine_state_reg[14] && machine_state_reg[28] |=>
    ((machine_state_reg ^ $past(machine_state_reg)) & ($past(guest_protect_register) | `SRM_MSR_GUEST_KEEP)) == 32'h0)
    else $error("protected machine state bit changed in guest state");
  chk_width_fetch: assert property (
    take && op_kind == srm_pkg::SRM_OP_MSR_WRITE && !machine_state_reg[14] &&
    op_operand[31] != machine_state_reg[31] && !(machine_state_reg[28] && guest_protect_register[31])
    |=> fetch_hi_clear && irq_recheck)
    else $error("width change without fetch clear");
  chk_clear_type: assert property (
    take && op_kind == srm_pkg::SRM_OP_MSG_CLR && hv && !msg_rx_valid |=>
    !msg_pending[$past(op_operand[31:27])])
    else $error("pending message not cleared");
  chk_bit_clear: assert property (
    take && op_kind == srm_pkg::SRM_OP_FP_BIT_CLR && machine_state_reg[13] && op_index > 5'd2 |=>
    !fp_status_control_reg[31-$past(op_index)])
    else $error("status bit not cleared");
endmodule : srm_checker
bind srm_top srm_checker i_chk (.clk, .rst_b, .op_valid, .op_kind, .op_operand, .op_field_mask, .op_index,
  .guest_protect_register, .msg_rx_valid, .msg_tx_ready, .op_ready, .op_done, .exc_priv, .exc_fp_unavail,
  .condition_register, .fp_status_control_reg, .machine_state_reg, .fetch_hi_clear, .irq_recheck,
  .msg_tx_valid, .msg_tx_type, .msg_tx_payload, .msg_pending, .barrier_ack);
`default_nettype wire

// file: verif/special_register_move_unit_bench.sv
/* Directed bench for srm_top: each scenario drives the op port and judges the outputs.
   Assumes a 40 MHz core clock; inputs change on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module special_register_move_unit_bench;
  logic clk, rst_b, op_valid, op_record, msg_rx_valid, msg_irq_taken, msg_tx_ready, barrier_req;
  srm_pkg::srm_op_type op_kind;
  logic [63:0] op_operand;
  logic [7:0] op_field_mask;
  logic [4:0] op_index, msg_rx_type, msg_irq_taken_type, dcr_rd_addr, msg_tx_type;
  logic [3:0] op_imm;
  logic [9:0] op_dcrn;
  logic [31:0] guest_protect_register, condition_register, fp_status_control_reg, machine_state_reg;
  logic [31:0] dcr_rd_data, msg_pending;
  logic op_ready, op_done, exc_priv, exc_fp_unavail, fetch_hi_clear, irq_recheck, msg_tx_valid, barrier_ack;
  logic [26:0] msg_tx_payload;
  logic [2:0] res;
  logic ack_seen;
  int errors, n_tests;
  srm_top i_dut (.clk, .rst_b, .op_valid, .op_kind, .op_operand, .op_field_mask, .op_index, .op_imm,
    .op_record, .op_dcrn, .guest_protect_register, .msg_rx_valid, .msg_rx_type, .msg_irq_taken,
    .msg_irq_taken_type, .msg_tx_ready, .barrier_req, .dcr_rd_addr, .op_ready, .op_done, .exc_priv,
    .exc_fp_unavail, .condition_register, .fp_status_control_reg, .machine_state_reg, .fetch_hi_clear,
    .irq_recheck, .msg_tx_valid, .msg_tx_type, .msg_tx_payload, .msg_pending, .barrier_ack, .dcr_rd_data);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // res collects {fp unavailable, privilege, done}; an extra cycle keeps op_valid edges apart
  // reserved fields of the fp moves have no port here, so they always reach the unit as zero
  task automatic op(input srm_pkg::srm_op_type k, input logic [63:0] d, input logic [7:0] m = 8'h00,
      input logic [4:0] ix = 5'h00, input logic [3:0] im = 4'h0, input logic rc = 1'b0);
    int n;
    op_kind = k;
    op_operand = d;
    op_field_mask = m;
    op_index = ix;
    op_imm = im;
    op_record = rc;
    op_valid = 1'b1;
    n = 0;
    while (op_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    op_valid = 1'b0;
    res = 3'b000;
    for (n = 0; n < 40 && res == 3'b000; n++) begin
      res = {exc_fp_unavail, exc_priv, op_done};
      @(negedge clk);
    end
  endtask : op
  task automatic t_unavail();
    op(srm_pkg::SRM_OP_FP_BIT_SET, 64'h0, 8'h00, 5'd5);
    chk(res, 3'b100);
    chk(fp_status_control_reg, 32'h0);
    $display("test unavail done");
  endtask : t_unavail
  task automatic t_cr();
    op(srm_pkg::SRM_OP_CR_WRITE, 64'hffff_ffff_1234_5678, 8'h81);
    chk(condition_register, 32'h1000_0008);
    op(srm_pkg::SRM_OP_CR_WRITE, 64'hffff_ffff, 8'h7e);
    chk(condition_register, 32'h1fff_fff8);
    $display("test cr done");
  endtask : t_cr
  task automatic t_dcr();
    op_dcrn = 10'h060;
    op(srm_pkg::SRM_OP_DCR_WRITE, 64'hdead_beef_0bad_cafe);
    dcr_rd_addr = 5'd3;
    repeat (3) @(negedge clk);
    chk(dcr_rd_data, 32'h0bad_cafe);
    op_dcrn = 10'h061;
    op(srm_pkg::SRM_OP_DCR_WRITE, 64'h5555_5555);
    chk({res, dcr_rd_data}, {3'b001, 32'h0bad_cafe});
    $display("test dcr done");
  endtask : t_dcr
  task automatic t_msg();
    barrier_req = 1'b1;
    ack_seen = 1'b0;
    fork
      op(srm_pkg::SRM_OP_MSG_SEND, {32'h0, 5'd9, 27'h123_4567});
      begin
        repeat (4) begin
          @(negedge clk);
          ack_seen = ack_seen | barrier_ack;
        end
        chk({msg_tx_valid, op_ready, msg_tx_type, msg_tx_payload}, {2'b10, 5'd9, 27'h123_4567});
        chk(ack_seen, 1'b0);
        msg_tx_ready = 1'b1;
        @(negedge clk);
        msg_tx_ready = 1'b0;
      end
    join
    chk(res, 3'b001);
    for (int n = 0; n < 6 && !ack_seen; n++) begin
      @(negedge clk);
      ack_seen = barrier_ack;
    end
    barrier_req = 1'b0;
    chk(ack_seen, 1'b1);
    msg_rx_type = 5'd9;
    msg_rx_valid = 1'b1;
    @(negedge clk);
    msg_rx_type = 5'd4;
    @(negedge clk);
    msg_rx_valid = 1'b0;
    chk(msg_pending, 32'h0000_0210);
    op(srm_pkg::SRM_OP_MSG_CLR, {32'h0, 5'd9, 27'h0});
    chk(msg_pending, 32'h0000_0010);
    op(srm_pkg::SRM_OP_MSG_CLR, {32'h0, 5'd9, 27'h0});
    chk({msg_pending, condition_register}, {32'h0000_0010, 32'h1fff_fff8});
    {msg_rx_valid, msg_irq_taken, msg_rx_type, msg_irq_taken_type} = {2'b11, 5'd4, 5'd4};
    @(negedge clk);
    msg_rx_valid = 1'b0;
    chk(msg_pending, 32'h0000_0010);
    @(negedge clk);
    msg_irq_taken = 1'b0;
    chk(msg_pending, 32'h0);
    $display("test msg done");
  endtask : t_msg
  task automatic t_fp();
    op(srm_pkg::SRM_OP_MSR_WRITE, 64'h0001_2000);
    chk(machine_state_reg, 32'h0001_2000);
    chk(msg_pending[9], 1'b0);
    op(srm_pkg::SRM_OP_FP_BIT_SET, 64'h0, 8'h00, 5'd3, 4'h0, 1'b1);
    chk({fp_status_control_reg, condition_register}, {32'h9000_0000, 32'h19ff_fff8});
    op(srm_pkg::SRM_OP_FP_BIT_SET, 64'h0, 8'h00, 5'd1);
    chk(fp_status_control_reg, 32'h9000_0000);
    op(srm_pkg::SRM_OP_FP_BIT_CLR, 64'h0, 8'h00, 5'd2);
    chk(fp_status_control_reg, 32'h9000_0000);
    op(srm_pkg::SRM_OP_FP_BIT_CLR, 64'h0, 8'h00, 5'd3);
    op(srm_pkg::SRM_OP_FP_BIT_CLR, 64'h0, 8'h00, 5'd0);
    chk(fp_status_control_reg, 32'h0);
    op(srm_pkg::SRM_OP_FP_FIELDS, 64'h0f00_0000, 8'h02);
    chk(fp_status_control_reg, 32'h2f00_0000);
    op(srm_pkg::SRM_OP_FP_FIELD_IMM, 64'h0, 8'h00, 5'd7, 4'h8, 1'b1);
    chk({fp_status_control_reg, condition_register[27:24]}, {32'h6f00_0008, 4'h6});
    op(srm_pkg::SRM_OP_FP_FIELD_IMM, 64'h0, 8'h00, 5'd0, 4'h9);
    chk(fp_status_control_reg, 32'hff00_0008);
    op(srm_pkg::SRM_OP_FP_FIELDS, 64'h0, 8'h01);
    chk(fp_status_control_reg, 32'h6f00_0008);
    $display("test fp done");
  endtask : t_fp
  task automatic t_guest();
    op(srm_pkg::SRM_OP_MSR_WRITE, 64'h1000_3000);
    op(srm_pkg::SRM_OP_MSR_WRITE, 64'h8000_2200);
    chk(machine_state_reg, 32'h9000_3000);
    op(srm_pkg::SRM_OP_DCR_WRITE, 64'h1);
    chk(res, 3'b010);
    op(srm_pkg::SRM_OP_MSG_SEND, 64'h1);
    chk({res, msg_tx_valid}, 4'b0100);
    op(srm_pkg::SRM_OP_MSR_WRITE, 64'h0000_4000);
    chk(machine_state_reg, 32'h1000_5000);
    op(srm_pkg::SRM_OP_MSR_WRITE, 64'h0);
    chk({res, machine_state_reg}, {3'b010, 32'h1000_5000});
    $display("test guest done");
  endtask : t_guest
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    rst_b = 1'b0;
    op_kind = srm_pkg::SRM_OP_CR_WRITE;
    guest_protect_register = 32'h0000_0200;
    {op_valid, op_record, msg_rx_valid, msg_irq_taken, msg_tx_ready, barrier_req, op_operand,
      op_field_mask, op_index, op_imm, op_dcrn, msg_rx_type, msg_irq_taken_type, dcr_rd_addr} = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_unavail();
    t_cr();
    t_dcr();
    t_msg();
    t_fp();
    t_guest();
    conclude();
  end
endmodule : special_register_move_unit_bench
`default_nettype wire
